// File: rtl/drc_ctrl.v
// host controller for a 64k x 1 multiplexed-address dynamic ram
// assumes requests come from logic on sys_clk; dout_pin is asynchronous
//
// Behaviour
// - refresh starts only from idle, with the column strobe high and no access open.
// - all 128 rows of the low seven address bits are refreshed within every 2 ms.
// - after power-up wait at least 100 us, then issue at least 8 row strobe cycles first.
// - write enable stays high past the strobe rising edges by the read hold time on reads.
// - the row half goes out with the row strobe and the column half with the column strobe.
// - page mode holds the row strobe low and cycles the column strobe per new column.
// - page mode keeps the column strobe high at least 100 ns between accesses.
// - row-only refresh cycles the row strobe with a row address and the column strobe high.
`timescale 1ns/1ps
`include "drc_defs.vh"

module drc_ctrl
#(
  parameter PWRUP_CYC   = `DRC_PWRUP_CYC,
  parameter REF_INT_CYC = `DRC_REF_INT_CYC
)
(
  // clock and reset
  input  wire        sys_clk,
  input  wire        nrst,
  // request side
  input  wire        req_valid,
  output wire        req_ready,
  input  wire [1:0]  req_op,
  input  wire [15:0] req_addr,
  input  wire        req_wdata,
  input  wire        req_page,
  output reg         rsp_valid_q,
  output reg         rsp_rdata_q,
  output wire        init_done,
  // memory pins
  output reg  [7:0]  mux_address_q,
  output reg         ras_n_q,
  output reg         cas_n_q,
  output reg         we_n_q,
  output reg         din_q,
  input  wire        dout_pin
);

  // ----------------------------------------------------------------
  // states and phase lengths
  // ----------------------------------------------------------------
  localparam S_PWRUP = 4'h0, S_INIT = 4'h1, S_IDLE = 4'h2, S_RCD = 4'h3;
  localparam S_CAS = 4'h4, S_RWD = 4'h5, S_WP = 4'h6, S_HOLD = 4'h7;
  localparam S_CP = 4'h8, S_RP = 4'h9, S_REF = 4'hA;

  localparam [15:0] C_RAS = `DRC_CYC(`DRC_T_RAS_NS);
  localparam [15:0] C_RP  = `DRC_CYC(`DRC_T_RP_NS);
  localparam [15:0] C_RCD = `DRC_CYC(`DRC_T_RCD_NS);
  localparam [15:0] C_CAS = `DRC_CYC(`DRC_T_CAS_NS);
  localparam [15:0] C_CP  = `DRC_CYC(`DRC_T_CP_NS);
  localparam [15:0] C_RWD = `DRC_CYC(`DRC_T_RWD_NS);
  localparam [15:0] C_WP  = `DRC_CYC(`DRC_T_WP_NS);
  localparam [15:0] C_RCH = `DRC_CYC(`DRC_T_RCH_NS);
  localparam [15:0] C_SYNC = `DRC_SYNC_STAGES;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg [3:0]  st_q;
  reg [3:0]  init_cnt_q;
  reg [6:0]  ref_row_q;
  reg        ref_due_q;
  reg [15:0] ref_tmr_q;
  reg [1:0]  op_q;
  reg [7:0]  row_q;
  reg        page_q;
  reg        init_q;
  reg        d1_q;
  reg        d2_q;
  reg        ld;
  reg [15:0] ld_val;
  wire       tdone;
  wire [15:0] pw_val = PWRUP_CYC[15:0];

  assign init_done = init_q;
  // a page hit continues in the open row; any other request needs idle
  assign req_ready = (st_q == S_IDLE && !ref_due_q) ||
                     (st_q == S_CP && tdone && page_q && !ref_due_q &&
                      req_addr[15:8] == row_q);

  drc_timer #(.W(16)) u_tmr
  (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .load    (ld),
    .value   (ld_val),
    .done    (tdone)
  );

  // ----------------------------------------------------------------
  // input synchroniser; dout comes from off chip
  // ----------------------------------------------------------------
  always @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      d1_q <= 1'b0;
      d2_q <= 1'b0;
    end
    else
    begin
      d1_q <= dout_pin;
      d2_q <= d1_q;
    end
  end

  // ----------------------------------------------------------------
  // refresh interval timer
  // ----------------------------------------------------------------
  always @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ref_tmr_q <= 16'h0000;
      ref_due_q <= 1'b0;
    end
    else
    begin
      if (ref_tmr_q == REF_INT_CYC[15:0] - 16'h0001)
        ref_tmr_q <= 16'h0000;
      else
        ref_tmr_q <= ref_tmr_q + 16'h0001;
      // set wins over clear
      if (init_q && ref_tmr_q == REF_INT_CYC[15:0] - 16'h0001)
        ref_due_q <= 1'b1;
      else if (st_q == S_REF)
        ref_due_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // phase timer loads
  // ----------------------------------------------------------------
  always @*
  begin
    ld = 1'b0;
    ld_val = 16'h0000;
    case (st_q)
      S_IDLE:
      begin
        ld = ref_due_q || req_valid;
        ld_val = ref_due_q ? C_RAS : C_RCD;
      end
      S_RCD:
      begin
        ld = tdone;
        ld_val = (op_q == `DRC_OP_RMW) ? C_RWD + C_SYNC : C_CAS + C_SYNC;
      end
      S_CAS, S_RWD:
      begin
        ld = tdone;
        ld_val = (st_q == S_RWD) ? C_WP : C_RCH;
      end
      S_WP, S_HOLD:
      begin
        ld = tdone;
        ld_val = page_q ? C_CP : C_RP;
      end
      S_CP:
      begin
        ld = tdone;
        if (!(req_ready && req_valid))
          ld_val = C_RP;
        else if (req_op == `DRC_OP_RMW)
          ld_val = C_RWD + C_SYNC;
        else
          ld_val = C_CAS + C_SYNC;
      end
      S_REF, S_INIT:
      begin
        ld = tdone;
        ld_val = (ras_n_q) ? C_RAS : C_RP;
      end
      S_RP:
      begin
        ld = tdone;
        ld_val = C_RAS;
      end
      default:
      begin
        ld = tdone && !init_q && st_q == S_PWRUP && init_cnt_q == 4'h0 && ras_n_q;
        ld_val = pw_val;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // main sequencer
  // ----------------------------------------------------------------
  always @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_q <= S_PWRUP;
      init_cnt_q <= 4'h0;
      ref_row_q <= 7'h00;
      op_q <= 2'h0;
      row_q <= 8'h00;
      page_q <= 1'b0;
      init_q <= 1'b0;
      mux_address_q <= 8'h00;
      ras_n_q <= 1'b1;
      cas_n_q <= 1'b1;
      we_n_q <= 1'b1;
      din_q <= 1'b0;
      rsp_valid_q <= 1'b0;
      rsp_rdata_q <= 1'b0;
    end
    else
    begin
      rsp_valid_q <= 1'b0;
      case (st_q)
        S_PWRUP:
        begin
          // first pass loads the pause, second sees it expire
          if (init_cnt_q == 4'h0 && tdone)
            init_cnt_q <= 4'h1;
          else if (tdone)
          begin
            init_cnt_q <= 4'h0;
            st_q <= S_INIT;
          end
        end
        S_INIT:
        begin
          if (tdone)
          begin
            ras_n_q <= !ras_n_q;
            if (!ras_n_q)
            begin
              if (init_cnt_q == `DRC_INIT_CYCLES - 1)
                st_q <= S_RP;
              init_cnt_q <= init_cnt_q + 4'h1;
            end
          end
        end
        S_IDLE:
        begin
          if (ref_due_q)
          begin
            mux_address_q <= {1'b0, ref_row_q};
            ras_n_q <= 1'b0;
            st_q <= S_REF;
          end
          else if (req_valid)
          begin
            op_q <= req_op;
            row_q <= req_addr[15:8];
            page_q <= req_page;
            mux_address_q <= req_addr[15:8];
            ras_n_q <= 1'b0;
            din_q <= req_wdata;
            we_n_q <= (req_op != `DRC_OP_WRITE);
            st_q <= S_RCD;
          end
        end
        S_RCD:
        begin
          if (tdone)
          begin
            mux_address_q <= req_addr[7:0];
            cas_n_q <= 1'b0;
            st_q <= (op_q == `DRC_OP_RMW) ? S_RWD : S_CAS;
          end
        end
        S_CAS:
        begin
          // the pulse runs two extra clocks so the synchroniser holds the bit
          if (tdone)
          begin
            if (op_q == `DRC_OP_READ)
              rsp_rdata_q <= d2_q;
            rsp_valid_q <= 1'b1;
            cas_n_q <= 1'b1;
            st_q <= S_HOLD;
          end
        end
        S_RWD:
        begin
          if (tdone)
          begin
            rsp_rdata_q <= d2_q;
            we_n_q <= 1'b0;
            st_q <= S_WP;
          end
        end
        S_WP, S_HOLD:
        begin
          if (tdone)
          begin
            we_n_q <= 1'b1;
            cas_n_q <= 1'b1;
            if (st_q == S_WP)
              rsp_valid_q <= 1'b1;
            if (page_q)
              st_q <= S_CP;
            else
            begin
              ras_n_q <= 1'b1;
              st_q <= S_RP;
            end
          end
        end
        S_CP:
        begin
          if (tdone)
          begin
            if (req_ready && req_valid)
            begin
              op_q <= req_op;
              page_q <= req_page;
              din_q <= req_wdata;
              we_n_q <= (req_op != `DRC_OP_WRITE);
              mux_address_q <= req_addr[7:0];
              cas_n_q <= 1'b0;
              st_q <= (req_op == `DRC_OP_RMW) ? S_RWD : S_CAS;
            end
            else
            begin
              ras_n_q <= 1'b1;
              st_q <= S_RP;
            end
          end
        end
        S_REF:
        begin
          if (tdone)
          begin
            ras_n_q <= 1'b1;
            ref_row_q <= ref_row_q + 7'h01;
            st_q <= S_RP;
          end
        end
        S_RP:
        begin
          if (tdone)
          begin
            init_q <= 1'b1;
            st_q <= S_IDLE;
          end
        end
        default:
          st_q <= S_IDLE;
      endcase
    end
  end

endmodule

// File: rtl/drc_defs.vh
// constants for the dynamic ram host controller
// assumes a 40 MHz sys_clk; timings use the slowest speed grade
`ifndef DRC_DEFS_VH
`define DRC_DEFS_VH

// ----------------------------------------------------------------
// timing figures as printed, in ns except power-up in us and refresh in ms
// ----------------------------------------------------------------
`define DRC_CLK_PERIOD_NS   25
`define DRC_T_RAS_NS        250
`define DRC_T_RP_NS         150
`define DRC_T_RCD_NS        35
`define DRC_T_CAS_NS        165
`define DRC_T_CP_NS         100
`define DRC_T_CPN_NS        35
`define DRC_T_RWD_NS        200
`define DRC_T_CWD_NS        115
`define DRC_T_WP_NS         75
`define DRC_T_RCH_NS        30
`define DRC_T_PWRUP_US      100
`define DRC_T_REF_MS        2

// least times round up to whole cycles
`define DRC_CYC(ns) (((ns) + `DRC_CLK_PERIOD_NS - 1) / `DRC_CLK_PERIOD_NS)

// ----------------------------------------------------------------
// counts
// ----------------------------------------------------------------
`define DRC_INIT_CYCLES     8
`define DRC_REF_ROWS        128
// the read bit reaches logic two clocks after it stands on the pin
`define DRC_SYNC_STAGES     2
`define DRC_PWRUP_CYC       ((`DRC_T_PWRUP_US * 1000) / `DRC_CLK_PERIOD_NS)
// refresh interval per row, rounded down so 128 rows fit in the period
`define DRC_REF_INT_CYC     ((`DRC_T_REF_MS * 1000000) / `DRC_CLK_PERIOD_NS / `DRC_REF_ROWS)

// ----------------------------------------------------------------
// request operation codes
// ----------------------------------------------------------------
`define DRC_OP_READ         2'h0
`define DRC_OP_WRITE        2'h1
`define DRC_OP_RMW          2'h2

`endif

// File: rtl/drc_timer.v
// down counter used for every strobe phase of the controller
// assumes a load pulse from logic on the same clock
`timescale 1ns/1ps

module drc_timer
#(
  parameter W = 16
)
(
  // clock and reset
  input  wire         sys_clk,
  input  wire         nrst,
  // control
  input  wire         load,
  input  wire [W-1:0] value,
  // status
  output wire         done
);

  reg [W-1:0] cnt_q;

  assign done = (cnt_q == {W{1'b0}});

  always @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      cnt_q <= {W{1'b0}};
    else if (load)
      cnt_q <= value;
    else if (!done)
      cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
  end

endmodule

// File: verification/drc_ctrl_checker.sv
// pin-level checker for the dram host controller
// assumes it is bound onto drc_ctrl; figures are sys_clk cycles
`timescale 1ns/1ps
module drc_ctrl_checker
#(
  parameter PWRUP_CYC   = 4000,
  parameter REF_INT_CYC = 625
)
(
  // clock and reset
  input wire       sys_clk,
  input wire       nrst,
  // request side
  input wire       req_ready,
  input wire       rsp_valid_q,
  input wire       init_done,
  // memory pins
  input wire [7:0] mux_address_q,
  input wire       ras_n_q,
  input wire       cas_n_q,
  input wire       we_n_q
);
  int up_q, rasf_q, cash_q, gap_q;

  // counters saturate so a long run cannot wrap them
  always @(posedge sys_clk or negedge nrst)
    if (!nrst)
    begin
      up_q   <= 0;
      rasf_q <= 0;
      cash_q <= 0;
      gap_q  <= 0;
    end
    else
    begin
      up_q   <= (up_q < PWRUP_CYC) ? up_q + 1 : up_q;
      rasf_q <= ($fell(ras_n_q) && rasf_q < 255) ? rasf_q + 1 : rasf_q;
      cash_q <= cas_n_q ? ((cash_q < 63) ? cash_q + 1 : cash_q) : 0;
      gap_q  <= $fell(ras_n_q) ? 0 : ((gap_q < 4095) ? gap_q + 1 : gap_q);
    end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  property p_pwrup; $fell(ras_n_q) |-> up_q >= PWRUP_CYC; endproperty
  a_pwrup: assert property (p_pwrup) else $error("row strobe inside pause");
  property p_dummy; $rose(init_done) |-> rasf_q >= 8; endproperty
  a_dummy: assert property (p_dummy) else $error("too few dummy cycles");
  property p_ready; req_ready |-> init_done; endproperty
  a_ready: assert property (p_ready) else $error("ready before init");
  property p_row_hold; $fell(ras_n_q) |=> $stable(mux_address_q); endproperty
  a_row_hold: assert property (p_row_hold) else $error("row address moved");
  property p_col_hold; $fell(cas_n_q) |=> $stable(mux_address_q) [*3]; endproperty
  a_col_hold: assert property (p_col_hold) else $error("column address moved");
  property p_cas_in_row; $fell(cas_n_q) |-> !ras_n_q; endproperty
  a_cas_in_row: assert property (p_cas_in_row) else $error("column without row");
  property p_gap; $fell(cas_n_q) |-> cash_q >= 4; endproperty
  a_gap: assert property (p_gap) else $error("column precharge short");
  property p_rd_hold; $rose(cas_n_q) && we_n_q |-> we_n_q [*2]; endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read hold broken");
  property p_refresh; init_done |-> gap_q < REF_INT_CYC + 64; endproperty
  a_refresh: assert property (p_refresh) else $error("refresh overdue");

  c_init: cover property ($rose(init_done));
  c_page: cover property (!ras_n_q && $rose(cas_n_q) ##[1:10] $fell(cas_n_q));
  c_rmw: cover property (!cas_n_q && $fell(we_n_q));
  c_rsp: cover property (rsp_valid_q);
endmodule

// File: verification/drc_ctrl_tb.sv
// self-checking bench for drc_ctrl against the behavioural ram
// assumes short power-up and refresh counts set below
`timescale 1ns/1ps
`include "drc_defs.vh"
module drc_ctrl_tb;
  localparam PWR = 20;
  localparam RI  = 200;
  logic        sys_clk = 1'b0;
  logic        nrst = 1'b0;
  logic        req_valid = 1'b0;
  logic [1:0]  req_op = 2'h0;
  logic [15:0] req_addr = 16'h0000;
  logic        req_wdata = 1'b0;
  logic        req_page = 1'b0;
  wire         req_ready, rsp_valid_q, rsp_rdata_q, init_done, dout_pin;
  wire  [7:0]  mux_address_q;
  wire         ras_n_q, cas_n_q, we_n_q, din_q;
  int          miscompares = 0;
  int          checks_done = 0;
  int          ref_mem [int];
  int          rasf, casf, pg_cas, refs, last_row;
  logic [7:0]  row;
  logic [1:0]  cur_op = 2'h0;
  logic [31:0] lfsr_q = 32'h4EB4272F;
  logic [15:0] aq [$];

  always #12.5 sys_clk = ~sys_clk;

  drc_ctrl #(.PWRUP_CYC(PWR), .REF_INT_CYC(RI)) dut (.sys_clk(sys_clk), .nrst(nrst),
    .req_valid(req_valid), .req_ready(req_ready), .req_op(req_op), .req_addr(req_addr),
    .req_wdata(req_wdata), .req_page(req_page), .rsp_valid_q(rsp_valid_q),
    .rsp_rdata_q(rsp_rdata_q), .init_done(init_done), .mux_address_q(mux_address_q),
    .ras_n_q(ras_n_q), .cas_n_q(cas_n_q), .we_n_q(we_n_q), .din_q(din_q), .dout_pin(dout_pin));
  drc_dram_model u_ram (.mux_address(mux_address_q), .ras_n(ras_n_q), .cas_n(cas_n_q),
    .we_n(we_n_q), .din(din_q), .dout(dout_pin));

  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input logic got, input logic exp, input string what);
    checks_done++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR %0t %s", $time, what);
    end
  endtask

  task automatic chk_v(input logic [15:0] got, input logic [15:0] exp, input string what);
    chk(got === exp, 1'b1, what);
  endtask

  task automatic tally_and_finish;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // one request, held until taken; the column address must stay put until the answer
  task automatic acc(input logic [1:0] op, input logic [15:0] a, input logic wd, input logic pg);
    int   n;
    logic e;
    e = ref_mem.exists(a) ? ref_mem[a][0] : 1'b0;
    cur_op = op;
    req_op <= op;
    req_addr <= a;
    req_wdata <= wd;
    req_page <= pg;
    req_valid <= 1'b1;
    n = 0;
    do begin @(negedge sys_clk); n++; end while (req_ready !== 1'b1 && n < 4000);
    chk(req_ready, 1'b1, "never ready");
    @(posedge sys_clk);
    req_valid <= 1'b0;
    n = 0;
    do begin @(negedge sys_clk); n++; end while (rsp_valid_q !== 1'b1 && n < 60);
    chk(rsp_valid_q, 1'b1, "no answer");
    if (op != `DRC_OP_WRITE) chk(rsp_rdata_q, e, "read data");
    if (op != `DRC_OP_READ) ref_mem[a] = wd;
    @(posedge sys_clk);
  endtask

  task automatic wait_init;
    int n;
    n = 0;
    do begin @(negedge sys_clk); n++; end while (init_done !== 1'b1 && n < 2000);
    chk(init_done, 1'b1, "init never ends");
    chk(rasf >= 8, 1'b1, "dummy cycles");
    @(posedge sys_clk);
  endtask

  // ----------------------------------------
  // pin monitors
  // ----------------------------------------
  always @(negedge ras_n_q)
  begin
    #1 row = mux_address_q;
    rasf++;
    casf = 0;
  end
  always @(posedge ras_n_q)
  begin
    pg_cas = casf;
    if (casf == 0 && init_done === 1'b1)
    begin
      chk(row[7], 1'b0, "refresh row bit");
      if (last_row >= 0) chk_v(row, (last_row + 1) % 128, "refresh order");
      last_row = row;
      refs++;
    end
  end
  always @(negedge cas_n_q)
  begin
    #1 casf++;
    if (init_done === 1'b1) chk(we_n_q, cur_op != `DRC_OP_WRITE, "write mode");
  end

  initial
  begin
    #(25 * 20000);
    miscompares++;
    $display("ERROR %0t watchdog", $time);
    tally_and_finish;
  end

  initial
  begin
    int n;
    rasf = 0;
    refs = 0;
    last_row = -1;
    repeat (12) @(posedge sys_clk);
    nrst <= 1'b1;
    @(negedge sys_clk);
    chk(req_ready, 1'b0, "ready in pause");
    wait_init();
    $display("test init done");
    for (int i = 0; i < 12; i++)
    begin
      lfsr_q = nxt(lfsr_q);
      aq.push_back(lfsr_q[15:0]);
      acc(`DRC_OP_WRITE, lfsr_q[15:0], lfsr_q[16], 1'b0);
    end
    foreach (aq[i])
    begin
      lfsr_q = nxt(lfsr_q);
      acc(i % 2 ? `DRC_OP_READ : `DRC_OP_RMW, aq[i], lfsr_q[0], 1'b0);
    end
    $display("test random access done");
    // each row starts just after a refresh so none splits the open row
    lfsr_q = nxt(lfsr_q);
    for (int k = 0; k < 3; k++)
    begin
      n = refs;
      while (refs == n) @(posedge sys_clk);
      for (int j = 0; j < 4; j++)
        acc(k == 0 ? `DRC_OP_WRITE : (k == 1 ? `DRC_OP_RMW : `DRC_OP_READ),
          {lfsr_q[15:8], 6'h00, j[1:0]}, lfsr_q[j] ^ (k == 1), j < 3);
      repeat (8) @(posedge sys_clk);
      chk_v(pg_cas, 4, "page accesses");
    end
    $display("test page done");
    refs = 0;
    repeat (3 * RI + 40) @(posedge sys_clk);
    chk(refs >= 3, 1'b1, "refresh count");
    $display("test refresh done");
    nrst <= 1'b0;
    repeat (12) @(posedge sys_clk);
    rasf = 0;
    last_row = -1;
    nrst <= 1'b1;
    wait_init();
    foreach (aq[i]) acc(`DRC_OP_READ, aq[i], 1'b0, 1'b0);
    $display("test second reset done");
    tally_and_finish;
  end
endmodule

bind drc_ctrl drc_ctrl_checker #(.PWRUP_CYC(PWRUP_CYC), .REF_INT_CYC(REF_INT_CYC)) u_chk (
  .sys_clk(sys_clk), .nrst(nrst), .req_ready(req_ready), .rsp_valid_q(rsp_valid_q),
  .init_done(init_done), .mux_address_q(mux_address_q), .ras_n_q(ras_n_q),
  .cas_n_q(cas_n_q), .we_n_q(we_n_q));

// File: verification/drc_dram_model.sv
// behavioural 64k x 1 dynamic ram driven by the controller pins
// assumes contents start at zero and survive a controller reset
`timescale 1ns/1ps
module drc_dram_model
#(
  parameter ACC_NS = 165
)
(
  // pins
  input  wire [7:0] mux_address,
  input  wire       ras_n,
  input  wire       cas_n,
  input  wire       we_n,
  input  wire       din,
  output wire       dout
);
  logic        mem [0:65535];
  logic [7:0]  row;
  logic [15:0] adr;
  logic        q = 1'b0;
  logic        drv = 1'b0;
  logic        col_open = 1'b0;

  initial
  begin
    for (int i = 0; i < 65536; i++) mem[i] = 1'b0;
  end
  // no pull on the line, so a released output shows the inverse bit
  assign dout = drv ? q : ~q;
  // strobe and address leave the controller on one edge; latch just after it
  always @(negedge ras_n) #1 row = mux_address;
  always @(negedge cas_n)
  begin
    drv = 1'b0;
    #1;
    adr = {row, mux_address};
    col_open = 1'b1;
    if (!we_n)
      mem[adr] = din;
    else
    begin
      q = mem[adr];
      #(ACC_NS);
      if (!cas_n) drv = 1'b1;
    end
  end
  // a write strobe that falls after the column strobe's fall is a late write
  always @(negedge we_n) if (col_open) mem[adr] = din;
  always @(posedge cas_n)
  begin
    drv = 1'b0;
    col_open = 1'b0;
  end
endmodule
